//--- verilog/xfer_pkg.sv
package xfer_pkg;

  // Page prefixes that introduce a two-byte opcode.
  localparam logic [7:0]  PAGE_27    = 8'h27;
  localparam logic [7:0]  PAGE_37    = 8'h37;

  // Full two-byte opcodes handled by this execute path.
  localparam logic [15:0] OPC_SIGN_EXTEND  = 16'h27F8;
  localparam logic [15:0] OPC_ROUNDED_TO_E = 16'h27B4;
  localparam logic [15:0] OPC_TRUNC_TO_E   = 16'h27B5;
  localparam logic [15:0] OPC_LOAD_E_D     = 16'h27B1;
  localparam logic [15:0] OPC_INDEX_MASKS  = 16'h372F;
  localparam logic [15:0] OPC_B_TO_Z_EXT   = 16'h379E;

  // Execution time of each transfer in core clock cycles.
  localparam logic [2:0]  CYC_SIGN_EXTEND  = 3'h2;
  localparam logic [2:0]  CYC_ROUNDED_TO_E = 3'h6;
  localparam logic [2:0]  CYC_TRUNC_TO_E   = 3'h2;
  localparam logic [2:0]  CYC_LOAD_E_D     = 3'h4;
  localparam logic [2:0]  CYC_INDEX_MASKS  = 3'h2;
  localparam logic [2:0]  CYC_B_TO_Z_EXT   = 3'h2;

  // Data constants.
  localparam logic [7:0]  BYTE_ONES  = 8'hFF;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [35:0] ROUND_BIAS = 36'h0_0000_8000;
  localparam logic [15:0] SAT_POS    = 16'h7FFF;
  localparam logic [15:0] SAT_NEG    = 16'h8000;

  // Transfer operations.
  typedef enum logic [2:0] {
    OP_NONE,
    OP_BYTE_SIGN_EXTEND,
    OP_ROUNDED_ACCUMULATOR_TO_E,
    OP_TRUNCATED_ACCUMULATOR_TO_E,
    OP_LOAD_ACCUMULATOR_FROM_E_D,
    OP_LOAD_INDEX_MASKS_FROM_D,
    OP_MOVE_B_TO_Z_EXTENSION
  } xfer_op_t;

  // Result of opcode decoding.
  typedef struct packed {
    xfer_op_t   op;
    logic [2:0] cycles;
  } decode_t;

  // Core register values presented by the register file.
  typedef struct packed {
    logic [7:0]  a;
    logic [7:0]  b;
    logic [15:0] d;
    logic [15:0] e;
    logic [35:0] mac_accumulator;
    logic        saturation_mode_flag;
    logic        extension_overflow_flag;
    logic        multiply_overflow_flag;
  } core_regs_t;

  // Values to write back into the register file.
  typedef struct packed {
    logic [7:0]  a;
    logic [15:0] e;
    logic [35:0] mac_accumulator;
    logic [7:0]  x_mask;
    logic [7:0]  y_mask;
    logic [3:0]  z_address_extension;
  } xfer_result_t;

  // One write enable per destination.
  typedef struct packed {
    logic a;
    logic e;
    logic mac_accumulator;
    logic x_mask;
    logic y_mask;
    logic z_address_extension;
  } xfer_wren_t;

endpackage : xfer_pkg

//--- verilog/mac_to_e_unit.sv
`timescale 1ns/1ps

module mac_to_e_unit (
  input  wire logic [35:0] mac_accumulator_i, // Multiply-accumulate register.
  input  wire logic        sat_mode_i,        // Saturation mode enable.
  input  wire logic        ext_ovf_i,         // Extension overflow flag.
  input  wire logic        mul_ovf_i,         // Multiply overflow flag.
  input  wire logic        round_i,           // High to round before taking bits.
  output logic      [15:0] e_value_o          // Value destined for E.
);
  import xfer_pkg::*;

  logic [35:0] temp;

  // Rounded or plain copy of the accumulator forms the temporary.
  assign temp = round_i ? (mac_accumulator_i + ROUND_BIAS) : mac_accumulator_i;

  // Saturation takes the sign of the accumulator; else bits 31:16 of the temporary are taken.
  always_comb begin
    if (sat_mode_i && (ext_ovf_i || mul_ovf_i)) begin
      e_value_o = mac_accumulator_i[35] ? SAT_NEG : SAT_POS;
    end else begin
      e_value_o = temp[31:16];
    end
  end

endmodule : mac_to_e_unit

//--- verilog/cpu_register_transfer_ops.sv
`timescale 1ns/1ps

module cpu_register_transfer_ops (
  input  wire logic                 core_clk_i, // Core clock, 25 MHz.
  input  wire logic                 rstn_i,     // Asynchronous reset, active low.
  input  wire logic                 op_valid_i, // Opcode byte valid.
  input  wire logic [7:0]           op_byte_i,  // Opcode byte from the decoder.
  input  wire xfer_pkg::core_regs_t regs_i,     // Current core register values.
  output logic                      busy_o,     // Transfer executing.
  output logic                      done_o,     // Pulse when results are written.
  output xfer_pkg::xfer_wren_t      wren_o,     // Destination write enables.
  output xfer_pkg::xfer_result_t    result_o    // Values to write back.
);
  import xfer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding.

  typedef enum logic [1:0] {ST_IDLE, ST_PREFIX, ST_EXEC} seq_state_t;

  seq_state_t   state;
  logic [7:0]   prefix;
  xfer_op_t     op;
  logic [2:0]   cnt;
  decode_t      decoded;
  logic         take;
  logic [15:0]  e_value;
  xfer_result_t next_result;

  // Maps a full two-byte opcode onto the operation and its cycle count.
  function automatic decode_t decode_op(input logic [15:0] code);
    decode_t d;
    d.op     = OP_NONE;
    d.cycles = 3'h0;
    case (code)
      OPC_SIGN_EXTEND: begin
        d.op     = OP_BYTE_SIGN_EXTEND;
        d.cycles = CYC_SIGN_EXTEND;
      end
      OPC_ROUNDED_TO_E: begin
        d.op     = OP_ROUNDED_ACCUMULATOR_TO_E;
        d.cycles = CYC_ROUNDED_TO_E;
      end
      OPC_TRUNC_TO_E: begin
        d.op     = OP_TRUNCATED_ACCUMULATOR_TO_E;
        d.cycles = CYC_TRUNC_TO_E;
      end
      OPC_LOAD_E_D: begin
        d.op     = OP_LOAD_ACCUMULATOR_FROM_E_D;
        d.cycles = CYC_LOAD_E_D;
      end
      OPC_INDEX_MASKS: begin
        d.op     = OP_LOAD_INDEX_MASKS_FROM_D;
        d.cycles = CYC_INDEX_MASKS;
      end
      OPC_B_TO_Z_EXT: begin
        d.op     = OP_MOVE_B_TO_Z_EXTENSION;
        d.cycles = CYC_B_TO_Z_EXT;
      end
      default: begin
        d.op     = OP_NONE;
        d.cycles = 3'h0;
      end
    endcase
    return d;
  endfunction : decode_op

  // The second byte is combined with the stored prefix before anything is chosen.
  assign decoded = decode_op({prefix, op_byte_i});
  assign take    = (state == ST_PREFIX) && op_valid_i && (decoded.op != OP_NONE);
  assign busy_o  = (state == ST_EXEC);

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing.

  // Prefix byte first, then the selecting byte, then a counted execution.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state  <= ST_IDLE;
      prefix <= 8'h00;
      op     <= OP_NONE;
      cnt    <= 3'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (op_valid_i && ((op_byte_i == PAGE_27) || (op_byte_i == PAGE_37))) begin
            state  <= ST_PREFIX;
            prefix <= op_byte_i;
          end
        end
        ST_PREFIX: begin
          if (take) begin
            state <= ST_EXEC;
            op    <= decoded.op;
            cnt   <= decoded.cycles - 3'h1;
          end else if (op_valid_i) begin
            state <= ST_IDLE;
          end
        end
        ST_EXEC: begin
          if (cnt == 3'h1) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - 3'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Datapath.

  mac_to_e_unit mac_to_e_unit_i (
    .mac_accumulator_i (regs_i.mac_accumulator),
    .sat_mode_i        (regs_i.saturation_mode_flag),
    .ext_ovf_i         (regs_i.extension_overflow_flag),
    .mul_ovf_i         (regs_i.multiply_overflow_flag),
    .round_i           (decoded.op == OP_ROUNDED_ACCUMULATOR_TO_E),
    .e_value_o         (e_value)
  );

  // Results are formed from the operands seen when the opcode is taken.
  always_comb begin
    next_result                     = result_o;
    next_result.a                   = regs_i.b[7] ? BYTE_ONES : BYTE_ZERO;
    next_result.e                   = e_value;
    next_result.mac_accumulator     = {{4{regs_i.e[15]}}, regs_i.e, regs_i.d};
    next_result.x_mask              = regs_i.d[15:8];
    next_result.y_mask              = regs_i.d[7:0];
    next_result.z_address_extension = regs_i.b[3:0];
  end

  // Result values are captured at take and held until the next take.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result_o <= '0;
    end else if (take) begin
      result_o <= next_result;
    end
  end

  // Write enables and done pulse in the cycle after the last execution cycle.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      done_o <= 1'b0;
      wren_o <= '0;
    end else begin
      done_o                     <= busy_o && (cnt == 3'h1);
      wren_o                     <= '0;
      if (busy_o && (cnt == 3'h1)) begin
        wren_o.a                   <= (op == OP_BYTE_SIGN_EXTEND);
        wren_o.e                   <= (op == OP_ROUNDED_ACCUMULATOR_TO_E) ||
                                      (op == OP_TRUNCATED_ACCUMULATOR_TO_E);
        wren_o.mac_accumulator     <= (op == OP_LOAD_ACCUMULATOR_FROM_E_D);
        wren_o.x_mask              <= (op == OP_LOAD_INDEX_MASKS_FROM_D);
        wren_o.y_mask              <= (op == OP_LOAD_INDEX_MASKS_FROM_D);
        wren_o.z_address_extension <= (op == OP_MOVE_B_TO_Z_EXTENSION);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  logic [35:0] round_sum;

  // Helper copy of the rounded temporary, read only by assertions.
  assign round_sum = regs_i.mac_accumulator + ROUND_BIAS;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_take_op(xfer_op_t o);
    take && (decoded.op == o);
  endsequence

  sequence s_sat_cond;
    regs_i.saturation_mode_flag && (regs_i.extension_overflow_flag || regs_i.multiply_overflow_flag);
  endsequence

  a_sign_fill: assert property (s_take_op(OP_BYTE_SIGN_EXTEND) |-> ##2 done_o && wren_o.a &&
    (result_o.a == ($past(regs_i.b[7], 2) ? BYTE_ONES : BYTE_ZERO)))
    else $error("Sign extension result wrong.");

  a_rounded_timing: assert property (s_take_op(OP_ROUNDED_ACCUMULATOR_TO_E) |=>
    busy_o [*5] ##1 (done_o && !busy_o && wren_o.e))
    else $error("Rounded transfer did not take six cycles.");

  a_rounded_sat_value: assert property ((s_take_op(OP_ROUNDED_ACCUMULATOR_TO_E) and s_sat_cond) |->
    ##6 (result_o.e == ($past(regs_i.mac_accumulator[35], 6) ? SAT_NEG : SAT_POS)))
    else $error("Rounded transfer did not saturate.");

  a_rounded_word: assert property ((s_take_op(OP_ROUNDED_ACCUMULATOR_TO_E) and !s_sat_cond) |->
    ##6 (result_o.e == $past(round_sum[31:16], 6)))
    else $error("Rounded transfer word wrong.");

  a_accum_load: assert property (s_take_op(OP_LOAD_ACCUMULATOR_FROM_E_D) |-> ##4 done_o &&
    wren_o.mac_accumulator && (result_o.mac_accumulator ==
    {{4{$past(regs_i.e[15], 4)}}, $past(regs_i.e, 4), $past(regs_i.d, 4)}))
    else $error("Accumulator load from E and D wrong.");

  a_mask_split: assert property (s_take_op(OP_LOAD_INDEX_MASKS_FROM_D) |-> ##2 done_o &&
    wren_o.x_mask && wren_o.y_mask && (result_o.x_mask == $past(regs_i.d[15:8], 2)) &&
    (result_o.y_mask == $past(regs_i.d[7:0], 2)))
    else $error("Index mask split wrong.");

  a_zext_move: assert property (s_take_op(OP_MOVE_B_TO_Z_EXTENSION) |-> ##2 done_o &&
    wren_o.z_address_extension && (result_o.z_address_extension == $past(regs_i.b[3:0], 2)))
    else $error("Z extension move wrong.");

  a_trunc_word: assert property ((s_take_op(OP_TRUNCATED_ACCUMULATOR_TO_E) and !s_sat_cond) |->
    ##2 done_o && wren_o.e && (result_o.e == $past(regs_i.mac_accumulator[31:16], 2)))
    else $error("Truncated transfer word wrong.");

  a_trunc_sat_value: assert property ((s_take_op(OP_TRUNCATED_ACCUMULATOR_TO_E) and s_sat_cond) |->
    ##2 done_o && wren_o.e && (result_o.e == ($past(regs_i.mac_accumulator[35], 2) ? SAT_NEG : SAT_POS)))
    else $error("Truncated transfer did not saturate.");

  a_single_byte_idle: assert property ((state == ST_IDLE) && op_valid_i |=> !busy_o)
    else $error("Execution started on a single byte.");

endmodule : cpu_register_transfer_ops

//--- bench/cpu_register_transfer_ops_tb.sv
`timescale 1ns/1ps

module cpu_register_transfer_ops_tb;
  import xfer_pkg::*;

  // One expected completion, noted by the driver when the opcode is taken.
  typedef struct {
    xfer_op_t    op;
    logic [35:0] val;
    logic [5:0]  wr;
    int          take;
    int          n;
  } note_t;

  localparam logic [15:0] OPCS [6] = '{OPC_SIGN_EXTEND, OPC_ROUNDED_TO_E, OPC_TRUNC_TO_E, OPC_LOAD_E_D,
                                       OPC_INDEX_MASKS, OPC_B_TO_Z_EXT};

  logic         core_clk_i;
  logic         rstn_i;
  logic         op_valid_i;
  logic [7:0]   op_byte_i;
  core_regs_t   regs_i;
  logic         busy_o;
  logic         done_o;
  xfer_wren_t   wren_o;
  xfer_result_t result_o;
  note_t        notes[$];
  note_t        mn;
  int           cyc = 0;
  int           fails = 0;
  int           check_count = 0;

  cpu_register_transfer_ops cpu_register_transfer_ops_i (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .op_valid_i (op_valid_i),
    .op_byte_i  (op_byte_i),
    .regs_i     (regs_i),
    .busy_o     (busy_o),
    .done_o     (done_o),
    .wren_o     (wren_o),
    .result_o   (result_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // The core clock toggles every 20 ns, giving 25 MHz.
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // A free-running edge count lets the monitor measure execution time.
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value against its expectation and reports a difference.
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  // Sends prefix and selector, notes the expected result and waits for completion.
  task automatic issue(input logic [15:0] opc, input int gap, input bit noise);
    note_t       nt;
    int          k;
    logic [35:0] rt;
    logic        sat;
    logic [15:0] sv;
    @(negedge core_clk_i);
    op_valid_i = 1'b1;
    op_byte_i  = opc[15:8];
    repeat (gap) begin
      @(negedge core_clk_i);
      op_valid_i = 1'b0;
    end
    @(negedge core_clk_i);
    regs_i     = 87'({$urandom, $urandom, $urandom});
    op_valid_i = 1'b1;
    op_byte_i  = opc[7:0];
    rt  = regs_i.mac_accumulator + ROUND_BIAS;
    sat = regs_i.saturation_mode_flag & (regs_i.extension_overflow_flag | regs_i.multiply_overflow_flag);
    sv  = regs_i.mac_accumulator[35] ? SAT_NEG : SAT_POS;
    // The edge count is noted in the selector's cycle, so done seen N cycles on gives a difference of N.
    nt  = '{OP_NONE, 36'h0_0000_0000, 6'h00, cyc, 0};
    case (opc)
      OPC_SIGN_EXTEND:  nt = '{OP_BYTE_SIGN_EXTEND, 36'(regs_i.b[7] ? BYTE_ONES : BYTE_ZERO), 6'h20, nt.take,
                               CYC_SIGN_EXTEND};
      OPC_ROUNDED_TO_E: nt = '{OP_ROUNDED_ACCUMULATOR_TO_E, 36'(sat ? sv : rt[31:16]), 6'h10, nt.take,
                               CYC_ROUNDED_TO_E};
      OPC_TRUNC_TO_E:   nt = '{OP_TRUNCATED_ACCUMULATOR_TO_E, 36'(sat ? sv : regs_i.mac_accumulator[31:16]), 6'h10,
                               nt.take, CYC_TRUNC_TO_E};
      OPC_LOAD_E_D:     nt = '{OP_LOAD_ACCUMULATOR_FROM_E_D, {{4{regs_i.e[15]}}, regs_i.e, regs_i.d}, 6'h08,
                               nt.take, CYC_LOAD_E_D};
      OPC_INDEX_MASKS:  nt = '{OP_LOAD_INDEX_MASKS_FROM_D, 36'(regs_i.d), 6'h06, nt.take, CYC_INDEX_MASKS};
      OPC_B_TO_Z_EXT:   nt = '{OP_MOVE_B_TO_Z_EXTENSION, 36'(regs_i.b[3:0]), 6'h01, nt.take, CYC_B_TO_Z_EXT};
      default:   nt.op = OP_NONE;
    endcase
    if (nt.op != OP_NONE) begin
      notes.push_back(nt);
    end
    @(negedge core_clk_i);
    op_valid_i = 1'b0;
    if (nt.op != OP_NONE) begin
      chk({35'h0, busy_o}, 36'h1);
    end
    // Bytes offered while busy must be ignored; the line drops once busy ends.
    for (k = 0; k < 12 && done_o !== 1'b1; k++) begin
      @(negedge core_clk_i);
      op_valid_i = noise && (busy_o === 1'b1);
      op_byte_i  = 8'($urandom);
    end
    if (nt.op != OP_NONE && done_o !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask : issue

  ////////////////////////////////////////////////////////////////////////////////
  // Takes the oldest note whenever a completion appears and checks it.
  always @(negedge core_clk_i) begin
    if (done_o === 1'b1) begin
      if (notes.size() == 0) begin
        chk(36'h1, 36'h0);
      end else begin
        mn = notes.pop_front();
        chk({30'h0, wren_o}, {30'h0, mn.wr});
        chk(36'(cyc - mn.take), 36'(mn.n));
        case (mn.op)
          OP_BYTE_SIGN_EXTEND:           chk({28'h0, result_o.a}, mn.val);
          OP_ROUNDED_ACCUMULATOR_TO_E:   chk({20'h0, result_o.e}, mn.val);
          OP_TRUNCATED_ACCUMULATOR_TO_E: chk({20'h0, result_o.e}, mn.val);
          OP_LOAD_ACCUMULATOR_FROM_E_D:  chk(result_o.mac_accumulator, mn.val);
          OP_LOAD_INDEX_MASKS_FROM_D:    chk({20'h0, result_o.x_mask, result_o.y_mask}, mn.val);
          OP_MOVE_B_TO_Z_EXTENSION:      chk({32'h0, result_o.z_address_extension}, mn.val);
          default:                       chk(36'h1, 36'h0);
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, every transfer many times, then refused byte pairs and one last rounded transfer.
  initial begin
    int i;
    rstn_i     = 1'b0;
    op_valid_i = 1'b0;
    op_byte_i  = 8'h00;
    regs_i     = '0;
    void'($urandom(32'hcc95));
    repeat (20) @(negedge core_clk_i);
    chk({28'h0, busy_o, done_o, wren_o}, 36'h0);
    rstn_i = 1'b1;
    for (i = 0; i < 16; i++) begin
      foreach (OPCS[j]) begin
        issue(OPCS[j], i % 3, i[0]);
      end
    end
    // Unknown selectors and a lone selector byte must produce nothing; a rounded transfer after a two-cycle prefix gap follows.
    issue(16'h2700, 0, 1'b0);
    issue(16'h37F8, 0, 1'b0);
    issue(16'h55B4, 0, 1'b0);
    issue(OPC_ROUNDED_TO_E, 2, 1'b1);
    // One more edge lets the monitor take the last note before the queue is counted.
    @(negedge core_clk_i);
    chk(36'(notes.size()), 36'h0);
    stop_test();
  end

endmodule : cpu_register_transfer_ops_tb
